// ---- rtl/udt_timer_regs.vh ----
`ifndef UDT_TIMER_REGS_VH
`define UDT_TIMER_REGS_VH

// register byte offsets (one aligned word each)
`define UDT_OFS_CONTROL      8'h00
`define UDT_OFS_MODE         8'h04
`define UDT_OFS_COUNT_LOW    8'h08
`define UDT_OFS_COUNT_HIGH   8'h0c
`define UDT_OFS_RELOAD_LOW   8'h10
`define UDT_OFS_RELOAD_HIGH  8'h14
`define UDT_ADDR_BITS        8

// timer_control_register fields
`define UDT_CTL_RUN          0
`define UDT_CTL_SOURCE       1
`define UDT_CTL_CAP_RELOAD   2
`define UDT_CTL_TX_CLOCK     4
`define UDT_CTL_RX_CLOCK     5
`define UDT_CTL_EXT_FLAG     6
`define UDT_CTL_OVF_FLAG     7

// timer_mode_register fields
`define UDT_MOD_UPDOWN       0
`define UDT_MOD_CLKOUT       1

// reset values
`define UDT_RST_CONTROL      8'h00
`define UDT_RST_MODE         2'h0
`define UDT_RST_BYTE         8'h00

// counter constants
`define UDT_COUNT_ALL_ONES   16'hffff
`define UDT_COUNT_ZERO       16'h0000
`define UDT_COUNT_ONE        16'h0001

// oscillator divide ratio for timer operation
`define UDT_PRESCALE_DIV     4'hc
`define UDT_PRESCALE_LAST    4'hb
`define UDT_PRESCALE_ZERO    4'h0
`define UDT_PRESCALE_STEP    4'h1

// ahb-lite encodings
`define UDT_HTRANS_NONSEQ_BIT 1
`define UDT_HRESP_OKAY       1'b0
`define UDT_WORD_ZERO        32'h00000000

`endif

// ---- rtl/udt_pin_sync.v ----
`timescale 1ns/1ps
// two-flop synchroniser for both pins plus a third stage for edge detection
module udt_pin_sync (
  input  wire hclk,
  input  wire hresetn,
  input  wire pin_count,
  input  wire pin_dir,
  output wire count_fall,
  output wire dir_level
);

  reg  [1:0] meta;
  reg  [1:0] stable;
  reg        count_prev;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta       <= 2'h0;
      stable     <= 2'h0;
      count_prev <= 1'b0;
    end else begin
      meta       <= {pin_dir, pin_count};
      stable     <= meta;
      count_prev <= stable[0];
    end
  end

  // external counting advances on a 1-to-0 transition of the pin
  assign count_fall = count_prev & ~stable[0];
  assign dir_level  = stable[1];

endmodule // udt_pin_sync

// ---- rtl/udt_timer.v ----
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "udt_timer_regs.vh"

//
// Function
// - count kept in two cascaded byte registers, low byte carries into high byte.
// - source select clear counts clock divided by 12, set counts external pin.
// - counter advances only while run control is set, otherwise holds.
// - three modes chosen by receive clock, transmit clock and capture/reload selects.
// - up/down enable clear gives plain up-counting auto-reload, direction pin ignored.
// - up-count past all ones sets overflow flag and raises interrupt request, except in baud mode.
// - up-count overflow loads the reload register pair into the counter, except capture mode wraps to zero.
// - down-count underflow detected when counter equals the reload register pair.
// - down-count underflow sets overflow flag and loads all ones.
// - extension flag inverts on every overflow or underflow in up/down operation.
// - extension flag toggling never requests an interrupt.
// - extension flag readable by software as a seventeenth count bit.
// - mode register resets with up/down enable and clock output enable cleared.
module udt_timer (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        external_count_pin,
  input  wire        direction_pin,
  output reg         timer_irq
);

  // control and mode state
  reg                 run_control;
  reg                 count_source_select;
  reg                 capture_reload_select;
  reg                 transmit_clock_select;
  reg                 receive_clock_select;
  reg                 extension_toggle_flag;
  reg                 overflow_flag;
  reg                 updown_enable;
  reg                 clock_output_enable;

  reg  [7:0]          count_low_byte;
  reg  [7:0]          count_high_byte;
  reg  [7:0]          reload_low_byte;
  reg  [7:0]          reload_high_byte;

  reg  [3:0]          prescale;
  reg                 prescale_pulse;

  // bus data-phase state
  reg                 wr_pending;
  reg                 rd_pending;
  reg  [`UDT_ADDR_BITS-1:0] wr_addr;
  reg  [`UDT_ADDR_BITS-1:0] rd_addr;

  wire                ext_fall;
  wire                dir_sync;

  reg  [7:0]          next_count_low;
  reg  [7:0]          next_count_high;
  reg                 next_overflow;
  reg                 next_extension;
  reg                 next_ovf_flag;
  reg                 next_ext_flag;

  wire [15:0]         count_word;
  wire [15:0]         reload_word;
  wire                tick;
  wire                counting_up;
  wire                low_carry;
  wire                low_borrow;
  wire                addr_phase;
  wire                sw_write;

  udt_pin_sync u_pin_sync (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pin_count  (external_count_pin),
    .pin_dir    (direction_pin),
    .count_fall (ext_fall),
    .dir_level  (dir_sync)
  );

  // mode decode, used only by the counting path
  function is_baud;
    input rx_clk;
    input tx_clk;
    begin
      is_baud = rx_clk | tx_clk;
    end
  endfunction

  function is_autoreload;
    input rx_clk;
    input tx_clk;
    input cap_rl;
    begin
      is_autoreload = ~is_baud(rx_clk, tx_clk) & ~cap_rl;
    end
  endfunction

  function is_capture;
    input rx_clk;
    input tx_clk;
    input cap_rl;
    begin
      is_capture = ~is_baud(rx_clk, tx_clk) & cap_rl;
    end
  endfunction

  // reload value after a down-count underflow
  localparam [15:0] down_reload_word = `UDT_COUNT_ALL_ONES;

  assign count_word  = {count_high_byte, count_low_byte};
  assign reload_word = {reload_high_byte, reload_low_byte};

  // divide-by-12 enable pulse; free running so the phase does not depend on run
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale       <= `UDT_PRESCALE_ZERO;
      prescale_pulse <= 1'b0;
    end else begin
      prescale_pulse <= (prescale == `UDT_PRESCALE_LAST);
      if (prescale == `UDT_PRESCALE_LAST) begin
        prescale <= `UDT_PRESCALE_ZERO;
      end else begin
        prescale <= prescale + `UDT_PRESCALE_STEP;
      end
    end
  end

  assign tick = run_control &
                (count_source_select ? ext_fall : prescale_pulse);

  // direction pin only steers counting in up/down auto-reload
  assign counting_up = ~(updown_enable &
                         is_autoreload(receive_clock_select, transmit_clock_select,
                                       capture_reload_select)) | dir_sync;

  assign low_carry  = (count_low_byte == 8'hff);
  assign low_borrow = (count_low_byte == 8'h00);

  // counting step; flags here are only the hardware-set part
  always @* begin
    next_count_low  = count_low_byte;
    next_count_high = count_high_byte;
    next_overflow   = 1'b0;
    next_extension  = 1'b0;
    if (tick) begin
      if (counting_up) begin
        if (count_word == `UDT_COUNT_ALL_ONES) begin
          if (is_capture(receive_clock_select, transmit_clock_select,
                         capture_reload_select)) begin
            next_count_low  = count_word[7:0] + 8'h01;
            next_count_high = count_word[15:8] + 8'h01;
            next_overflow   = 1'b1;
          end else begin
            next_count_low  = reload_low_byte;
            next_count_high = reload_high_byte;
            // baud mode reloads silently
            next_overflow   = ~is_baud(receive_clock_select, transmit_clock_select);
            next_extension  = updown_enable &
                              is_autoreload(receive_clock_select, transmit_clock_select,
                                            capture_reload_select);
          end
        end else begin
          next_count_low = count_low_byte + 8'h01;
          if (low_carry) begin
            next_count_high = count_high_byte + 8'h01;
          end
        end
      end else begin
        if (count_word == reload_word) begin
          next_count_low  = down_reload_word[7:0];
          next_count_high = down_reload_word[15:8];
          next_overflow   = 1'b1;
          next_extension  = 1'b1;
        end else begin
          next_count_low = count_low_byte - 8'h01;
          if (low_borrow) begin
            next_count_high = count_high_byte - 8'h01;
          end
        end
      end
    end
  end

  // ahb-lite slave: writes land at the end of the data phase,
  // reads take one wait state so a preceding write is always visible
  assign addr_phase = hsel & htrans[`UDT_HTRANS_NONSEQ_BIT] & hready;
  assign sw_write   = wr_pending;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      wr_addr    <= {`UDT_ADDR_BITS{1'b0}};
      rd_addr    <= {`UDT_ADDR_BITS{1'b0}};
      hreadyout  <= 1'b1;
      hresp      <= `UDT_HRESP_OKAY;
    end else begin
      wr_pending <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr <= haddr[`UDT_ADDR_BITS-1:0];
        rd_addr <= haddr[`UDT_ADDR_BITS-1:0];
      end
      rd_pending <= addr_phase & ~hwrite;
      hreadyout  <= ~(addr_phase & ~hwrite);
      hresp      <= `UDT_HRESP_OKAY;
    end
  end

  // read mux; reserved bits read zero, unmapped words read zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `UDT_WORD_ZERO;
    end else if (rd_pending) begin
      case (rd_addr)
        `UDT_OFS_CONTROL: begin
          hrdata <= {24'h000000, overflow_flag, extension_toggle_flag,
                     receive_clock_select, transmit_clock_select, 1'b0,
                     capture_reload_select, count_source_select, run_control};
        end
        `UDT_OFS_MODE: begin
          hrdata <= {30'h00000000, clock_output_enable, updown_enable};
        end
        `UDT_OFS_COUNT_LOW: begin
          hrdata <= {24'h000000, count_low_byte};
        end
        `UDT_OFS_COUNT_HIGH: begin
          hrdata <= {24'h000000, count_high_byte};
        end
        `UDT_OFS_RELOAD_LOW: begin
          hrdata <= {24'h000000, reload_low_byte};
        end
        `UDT_OFS_RELOAD_HIGH: begin
          hrdata <= {24'h000000, reload_high_byte};
        end
        default: begin
          hrdata <= `UDT_WORD_ZERO;
        end
      endcase
    end
  end

  // control and mode registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_control           <= 1'b0;
      count_source_select   <= 1'b0;
      capture_reload_select <= 1'b0;
      transmit_clock_select <= 1'b0;
      receive_clock_select  <= 1'b0;
      updown_enable         <= 1'b0;
      clock_output_enable   <= 1'b0;
    end else if (sw_write) begin
      if (wr_addr == `UDT_OFS_CONTROL) begin
        run_control           <= hwdata[`UDT_CTL_RUN];
        count_source_select   <= hwdata[`UDT_CTL_SOURCE];
        capture_reload_select <= hwdata[`UDT_CTL_CAP_RELOAD];
        transmit_clock_select <= hwdata[`UDT_CTL_TX_CLOCK];
        receive_clock_select  <= hwdata[`UDT_CTL_RX_CLOCK];
      end
      if (wr_addr == `UDT_OFS_MODE) begin
        updown_enable       <= hwdata[`UDT_MOD_UPDOWN];
        clock_output_enable <= hwdata[`UDT_MOD_CLKOUT];
      end
    end
  end

  // flags: a hardware event in the same cycle as a software write wins
  always @* begin
    next_ovf_flag = overflow_flag;
    next_ext_flag = extension_toggle_flag;
    if (next_overflow) begin
      next_ovf_flag = 1'b1;
    end else if (sw_write && wr_addr == `UDT_OFS_CONTROL) begin
      next_ovf_flag = hwdata[`UDT_CTL_OVF_FLAG];
    end
    if (next_extension) begin
      next_ext_flag = ~extension_toggle_flag;
    end else if (sw_write && wr_addr == `UDT_OFS_CONTROL) begin
      next_ext_flag = hwdata[`UDT_CTL_EXT_FLAG];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag         <= 1'b0;
      extension_toggle_flag <= 1'b0;
    end else begin
      overflow_flag         <= next_ovf_flag;
      extension_toggle_flag <= next_ext_flag;
    end
  end

  // counter and reload bytes; software write to a count byte beats a tick
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_low_byte   <= `UDT_RST_BYTE;
      count_high_byte  <= `UDT_RST_BYTE;
      reload_low_byte  <= `UDT_RST_BYTE;
      reload_high_byte <= `UDT_RST_BYTE;
    end else begin
      if (sw_write && wr_addr == `UDT_OFS_COUNT_LOW) begin
        count_low_byte <= hwdata[7:0];
      end else begin
        count_low_byte <= next_count_low;
      end
      if (sw_write && wr_addr == `UDT_OFS_COUNT_HIGH) begin
        count_high_byte <= hwdata[7:0];
      end else begin
        count_high_byte <= next_count_high;
      end
      if (sw_write && wr_addr == `UDT_OFS_RELOAD_LOW) begin
        reload_low_byte <= hwdata[7:0];
      end
      if (sw_write && wr_addr == `UDT_OFS_RELOAD_HIGH) begin
        reload_high_byte <= hwdata[7:0];
      end
    end
  end

  // only the overflow flag requests an interrupt, never the extension flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq <= 1'b0;
    end else begin
      // follows the flag's next value so a software clear drops it at once
      timer_irq <= next_ovf_flag;
    end
  end

endmodule // udt_timer

// ---- verification/udt_timer_chk.sv ----
`timescale 1ns/1ps
module udt_timer_chk (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic        timer_irq
);
  logic take;
  logic rd_d;
  logic wr_d;
  assign take = hsel && htrans[1] && hready;
  // data-phase markers for the transfer just accepted
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_d <= 1'h0;
      wr_d <= 1'h0;
    end else begin
      rd_d <= take && !hwrite;
      wr_d <= take && hwrite;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hresp == 1'h0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_go; take && hwrite |=> hreadyout; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write stalled");
  property p_one_wait; !hreadyout |=> hreadyout; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait too long");
  property p_wait_cause; $fell(hreadyout) |-> rd_d; endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait without read");
  property p_rdata_hold; $changed(hrdata) |-> $past(rd_d); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_upper; hreadyout |-> hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_irq_sticky; timer_irq && !wr_d |=> timer_irq; endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped");
endmodule // udt_timer_chk

bind udt_timer udt_timer_chk i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .timer_irq(timer_irq)
);

// ---- verification/updown_autoreload_timer_tb.sv ----
`timescale 1ns/1ps
`include "udt_timer_regs.vh"
module updown_autoreload_timer_tb;
  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  mode;
    logic        dir;
    logic [15:0] rel;
    logic [15:0] cnt;
    logic [3:0]  n;
    logic [15:0] ecnt;
    logic [7:0]  ectl;
  } udt_row_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  wire         hready;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  logic        external_count_pin;
  logic        direction_pin;
  wire         timer_irq;
  logic [31:0] rq;
  integer      bad_count = 0;
  integer      n_compared = 0;
  integer      cyc = 0;
  integer      i;
  integer      t1;
  integer      t2;
  udt_row_t rows [0:9] = '{
    '{8'h03, 8'h02, 1'h0, 16'h1234, 16'hfffe, 4'h2, 16'h1234, 8'h83},
    '{8'h03, 8'h01, 1'h1, 16'h1234, 16'hfffe, 4'h2, 16'h1234, 8'hc3},
    '{8'h03, 8'h01, 1'h0, 16'h0010, 16'h0012, 4'h2, 16'h0010, 8'h03},
    '{8'h03, 8'h01, 1'h0, 16'h0010, 16'h0012, 4'h3, 16'hffff, 8'hc3},
    '{8'h03, 8'h00, 1'h1, 16'h0000, 16'h00ff, 4'h1, 16'h0100, 8'h03},
    '{8'h03, 8'h01, 1'h0, 16'h0000, 16'h0100, 4'h1, 16'h00ff, 8'h03},
    '{8'h02, 8'h00, 1'h1, 16'h0000, 16'h0abc, 4'h3, 16'h0abc, 8'h02},
    '{8'h13, 8'h00, 1'h1, 16'h1234, 16'hfffe, 4'h2, 16'h1234, 8'h13},
    '{8'h23, 8'h00, 1'h1, 16'h1234, 16'hfffe, 4'h2, 16'h1234, 8'h23},
    '{8'h07, 8'h00, 1'h1, 16'h1234, 16'hfffe, 4'h2, 16'h0000, 8'h87}
  };
  assign hready = hreadyout;
  udt_timer i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_count_pin(external_count_pin),
    .direction_pin(direction_pin), .timer_irq(timer_irq)
  );
  initial begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    begin
      k = 0;
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'h1 && k < 50) begin
        @(posedge hclk);
        k = k + 1;
      end
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'h1 && k < 50) begin
        @(posedge hclk);
        k = k + 1;
      end
      rq = hrdata;
      if (k >= 50) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: bus wait ran out", $time);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, {24'h0, d});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      xfer(1'h0, a, 32'h0);
      chk(rq, e);
    end
  endtask
  // falling edge counts; held long enough to pass the pin synchroniser
  task pulse;
    begin
      external_count_pin <= 1'h0;
      repeat (4) @(posedge hclk);
      external_count_pin <= 1'h1;
      repeat (4) @(posedge hclk);
    end
  endtask
  task load(input logic [15:0] rel, input logic [15:0] cnt);
    begin
      wr(`UDT_OFS_RELOAD_LOW, rel[7:0]);
      wr(`UDT_OFS_RELOAD_HIGH, rel[15:8]);
      wr(`UDT_OFS_COUNT_LOW, cnt[7:0]);
      wr(`UDT_OFS_COUNT_HIGH, cnt[15:8]);
    end
  endtask
  task do_row(input udt_row_t r);
    begin
      direction_pin <= r.dir;
      wr(`UDT_OFS_CONTROL, 8'h00);
      wr(`UDT_OFS_MODE, r.mode);
      rd(`UDT_OFS_MODE, {24'h0, r.mode});
      load(r.rel, r.cnt);
      wr(`UDT_OFS_CONTROL, r.ctl);
      repeat (r.n) pulse;
      repeat (6) @(posedge hclk);
      rd(`UDT_OFS_CONTROL, {24'h0, r.ectl});
      chk({31'h0, timer_irq}, {31'h0, r.ectl[7]});
      wr(`UDT_OFS_CONTROL, r.ctl & 8'h3e);
      rd(`UDT_OFS_COUNT_LOW, {24'h0, r.ecnt[7:0]});
      rd(`UDT_OFS_COUNT_HIGH, {24'h0, r.ecnt[15:8]});
    end
  endtask
  task wait_irq(output integer t);
    integer k;
    begin
      k = 0;
      do begin
        @(posedge hclk);
        k = k + 1;
      end while (timer_irq !== 1'h1 && k < 40);
      if (timer_irq !== 1'h1) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: interrupt wait ran out", $time);
      end
      t = cyc;
    end
  endtask
  task wrap_up;
    begin
      $display("mismatches %0d of %0d checks", bad_count, n_compared);
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count = bad_count + 1;
    wrap_up;
  end
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    external_count_pin = 1'h1;
    direction_pin = 1'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (i = 0; i < 7; i = i + 1) rd(8'(4 * i), 32'h0);
    chk({31'h0, timer_irq}, 32'h0);
    wr(8'h18, 8'h5a);
    rd(8'h18, 32'h0);
    for (i = 0; i < 10; i = i + 1) do_row(rows[i]);
    // extension flag alone must stay quiet on the interrupt line
    wr(`UDT_OFS_CONTROL, 8'h40);
    rd(`UDT_OFS_CONTROL, 32'h40);
    chk({31'h0, timer_irq}, 32'h0);
    wr(`UDT_OFS_MODE, 8'h00);
    load(16'hffff, 16'hffff);
    wr(`UDT_OFS_CONTROL, 8'h01);
    wait_irq(t1);
    wr(`UDT_OFS_CONTROL, 8'h01);
    wait_irq(t2);
    chk(t2 - t1, 32'h0000000c);
    // reset in mid-run with a flag up and up/down enabled
    wr(`UDT_OFS_MODE, 8'h01);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    chk({31'h0, timer_irq}, 32'h0);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(`UDT_OFS_CONTROL, 32'h0);
    rd(`UDT_OFS_MODE, 32'h0);
    rd(`UDT_OFS_COUNT_LOW, 32'h0);
    rd(`UDT_OFS_COUNT_HIGH, 32'h0);
    wrap_up;
  end
endmodule // updown_autoreload_timer_tb
